// file: output_channel_common_config_consts.svh
`ifndef OUTPUT_CHANNEL_COMMON_CONFIG_CONSTS_SVH
`define OUTPUT_CHANNEL_COMMON_CONFIG_CONSTS_SVH

// register word addresses on the internal configuration port
`define OCC_ADDR_COMMON_CONTROL 7'h3B
`define OCC_ADDR_SPARE_A 7'h3C
`define OCC_ADDR_DIV_CLK_SEL 7'h3D
`define OCC_ADDR_SPARE_B 7'h3E
`define OCC_ADDR_SPARE_C 7'h3F
`define OCC_ADDR_DEBUG_SPARE 7'h42

// reset values
`define OCC_RST_COMMON_CONTROL 16'h0079
`define OCC_RST_SPARE_A 16'h0018
`define OCC_RST_DIV_CLK_SEL 16'h1500
`define OCC_RST_SPARE_B 16'h4210
`define OCC_RST_SPARE_C 16'h0210
`define OCC_RST_DEBUG_SPARE 16'h0200

// common control word fields
`define OCC_BIT_ALL_RESET 13
`define OCC_CM_INC_HI 12
`define OCC_CM_INC_LO 11
`define OCC_CM_DEC_HI 10
`define OCC_CM_DEC_LO 9
`define OCC_IBIAS_HI 8
`define OCC_IBIAS_LO 5
`define OCC_BIT_CMOS_FAST 4
`define OCC_REFCOPY_HI 2
`define OCC_REFCOPY_LO 1

// divider clock select: channel n sits at bit DIVSEL_BASE + n - 1
`define OCC_DIVSEL_BASE 4

// reference-copy drive codes
`define OCC_REFCOPY_OFF 2'h0
`define OCC_REFCOPY_FAST 2'h3

// tail current decode, microamps
`define OCC_IBIAS_CODE_350 4'hC
`define OCC_IBIAS_CODE_400 4'h8
`define OCC_IBIAS_CODE_450 4'h4
`define OCC_IBIAS_CODE_500 4'h0
`define OCC_IBIAS_CODE_550 4'h1
`define OCC_IBIAS_CODE_600 4'h2
`define OCC_IBIAS_CODE_650 4'h3
`define OCC_UA_350 10'h15E
`define OCC_UA_400 10'h190
`define OCC_UA_450 10'h1C2
`define OCC_UA_500 10'h1F4
`define OCC_UA_550 10'h226
`define OCC_UA_600 10'h258
`define OCC_UA_650 10'h28A
`define OCC_UA_NONE 10'h000

`endif

// file: output_channel_common_config_pkg.sv
`default_nettype none

package output_channel_common_config_pkg;
    typedef logic [15:0] word_t;
    typedef logic [6:0] addr_t;
    typedef logic [9:0] microamp_t;
    localparam int unsigned NUM_REGS = 6;
endpackage

`default_nettype wire

// file: output_channel_common_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "output_channel_common_config_consts.svh"

module output_channel_common_config #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic core_clk, // register clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire output_channel_common_config_pkg::addr_t reg_addr, // word address
    input wire output_channel_common_config_pkg::word_t reg_wdata, // write data
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    output output_channel_common_config_pkg::word_t reg_rdata, // read data
    output logic reg_rvalid, // read data valid pulse
    output logic all_channel_reset, // hold all output channels in reset
    output logic [1:0] cm_trim_inc, // common-mode raise trim
    output logic [1:0] cm_trim_dec, // common-mode lower trim
    output logic [3:0] tail_current_trim, // tail current code
    output output_channel_common_config_pkg::microamp_t tail_current_ua, // decoded current
    output logic tail_current_valid, // code is a decodable value
    output logic channel_cmos_fast, // cmos drive for channels 1-4
    output logic reference_copy_output_enable, // reference copy on
    output logic reference_copy_output_fast, // reference copy fast drive
    output logic [NUM_CHANNELS-1:0] divider_clock_select // 1 direct, 0 integer divider
);

    localparam int NREG = output_channel_common_config_pkg::NUM_REGS;

    // only four fractional dividers exist behind the select bits
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 4) begin : g_bad_channels
        $error("NUM_CHANNELS must be 1 to 4");
    end

    localparam output_channel_common_config_pkg::addr_t REG_ADDR [NREG] = '{
        `OCC_ADDR_COMMON_CONTROL, `OCC_ADDR_SPARE_A, `OCC_ADDR_DIV_CLK_SEL,
        `OCC_ADDR_SPARE_B, `OCC_ADDR_SPARE_C, `OCC_ADDR_DEBUG_SPARE
    };
    localparam output_channel_common_config_pkg::word_t REG_RST [NREG] = '{
        `OCC_RST_COMMON_CONTROL, `OCC_RST_SPARE_A, `OCC_RST_DIV_CLK_SEL,
        `OCC_RST_SPARE_B, `OCC_RST_SPARE_C, `OCC_RST_DEBUG_SPARE
    };

    output_channel_common_config_pkg::word_t regs_r [NREG];
    logic [NREG-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            assign hit[gi] = (reg_addr == REG_ADDR[gi]);
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    regs_r[gi] <= REG_RST[gi];
                end else if (reg_wr && hit[gi]) begin
                    regs_r[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    output_channel_common_config_pkg::word_t rdata_nxt;
    always_comb begin
        rdata_nxt = 16'h0000;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rdata_nxt = regs_r[i];
            end
        end
    end

    // read back; unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    output_channel_common_config_pkg::word_t ctl;
    output_channel_common_config_pkg::word_t sel;
    assign ctl = regs_r[0];
    assign sel = regs_r[2];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            all_channel_reset <= 1'b0;
        end else begin
            all_channel_reset <= ctl[`OCC_BIT_ALL_RESET];
        end
    end

    // trims passed as written; exclusivity is software's to keep
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cm_trim_inc <= 2'h0;
            cm_trim_dec <= 2'h0;
        end else begin
            cm_trim_inc <= ctl[`OCC_CM_INC_HI:`OCC_CM_INC_LO];
            cm_trim_dec <= ctl[`OCC_CM_DEC_HI:`OCC_CM_DEC_LO];
        end
    end

    output_channel_common_config_pkg::microamp_t ua_nxt;
    always_comb begin
        unique case (ctl[`OCC_IBIAS_HI:`OCC_IBIAS_LO])
            `OCC_IBIAS_CODE_350: ua_nxt = `OCC_UA_350;
            `OCC_IBIAS_CODE_400: ua_nxt = `OCC_UA_400;
            `OCC_IBIAS_CODE_450: ua_nxt = `OCC_UA_450;
            `OCC_IBIAS_CODE_500: ua_nxt = `OCC_UA_500;
            `OCC_IBIAS_CODE_550: ua_nxt = `OCC_UA_550;
            `OCC_IBIAS_CODE_600: ua_nxt = `OCC_UA_600;
            `OCC_IBIAS_CODE_650: ua_nxt = `OCC_UA_650;
            // undefined codes leave the buffer current unspecified
            default: ua_nxt = `OCC_UA_NONE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tail_current_trim <= 4'h3;
            tail_current_ua <= `OCC_UA_650;
            tail_current_valid <= 1'b1;
        end else begin
            tail_current_trim <= ctl[`OCC_IBIAS_HI:`OCC_IBIAS_LO];
            tail_current_ua <= ua_nxt;
            tail_current_valid <= (ua_nxt != `OCC_UA_NONE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            channel_cmos_fast <= 1'b1;
            reference_copy_output_enable <= 1'b0;
            reference_copy_output_fast <= 1'b0;
        end else begin
            channel_cmos_fast <= ctl[`OCC_BIT_CMOS_FAST];
            reference_copy_output_enable <=
                (ctl[`OCC_REFCOPY_HI:`OCC_REFCOPY_LO] != `OCC_REFCOPY_OFF);
            reference_copy_output_fast <=
                (ctl[`OCC_REFCOPY_HI:`OCC_REFCOPY_LO] == `OCC_REFCOPY_FAST);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            divider_clock_select <= '0;
        end else begin
            divider_clock_select <= sel[`OCC_DIVSEL_BASE +: NUM_CHANNELS];
        end
    end

endmodule // output_channel_common_config

`default_nettype wire

// file: output_channel_common_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
module common_config_checker #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [6:0] reg_addr, // address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid, // read valid
    input wire logic all_channel_reset, // channel reset
    input wire logic [3:0] tail_current_trim, // tail trim
    input wire logic channel_cmos_fast, // cmos drive
    input wire logic reference_copy_output_enable, // ref copy on
    input wire logic reference_copy_output_fast, // ref copy fast
    input wire logic [NUM_CHANNELS-1:0] divider_clock_select // divider select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic cw;
    assign cw = reg_wr && reg_addr == 7'h3B;
    a_chan_reset_bit: assert property (cw |-> ##2
        all_channel_reset == $past(reg_wdata[13], 2)) else $error("channel reset bit wrong");
    a_tail_trim_field: assert property (cw |-> ##2
        tail_current_trim == $past(reg_wdata[8:5], 2)) else $error("tail trim wrong");
    a_cmos_drive_bit: assert property (cw |-> ##2
        channel_cmos_fast == $past(reg_wdata[4], 2)) else $error("cmos drive wrong");
    a_refcopy_drive: assert property (cw |-> ##2
        reference_copy_output_enable == ($past(reg_wdata[2:1], 2) != 2'h0)
        && reference_copy_output_fast == ($past(reg_wdata[2:1], 2) == 2'h3))
        else $error("ref copy drive wrong");
    a_divider_select: assert property (reg_wr && reg_addr == 7'h3D |-> ##2
        divider_clock_select == $past(reg_wdata[3+NUM_CHANNELS:4], 2))
        else $error("divider select wrong");
    a_reset_state: assert property ($fell(sys_rst) |-> !all_channel_reset
        && channel_cmos_fast && tail_current_trim == 4'h3 && divider_clock_select == '0)
        else $error("reset state wrong");
    a_read_pulse: assert property (reg_rvalid == $past(reg_rd)) else $error("read valid wrong");
    a_write_readback: assert property (reg_wr && reg_addr == 7'h3C ##1 !reg_wr [*2]
        ##1 reg_rd && reg_addr == 7'h3C |=> reg_rdata == $past(reg_wdata, 4))
        else $error("readback wrong");
endmodule // common_config_checker
`default_nettype wire

// file: output_channel_common_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_channel_common_config_tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, d;
    logic [1:0] cm_trim_inc, cm_trim_dec;
    logic [3:0] tail_current_trim, divider_clock_select;
    logic [9:0] tail_current_ua;
    logic reg_rvalid, all_channel_reset, tail_current_valid, channel_cmos_fast;
    logic reference_copy_output_enable, reference_copy_output_fast;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [22:0] ROWS [6] = '{{7'h3B, 16'h0079}, {7'h3C, 16'h0018},
        {7'h3D, 16'h1500}, {7'h3E, 16'h4210}, {7'h3F, 16'h0210}, {7'h42, 16'h0200}};
    localparam logic [3:0] CODES [7] = '{4'hC, 4'h8, 4'h4, 4'h0, 4'h1, 4'h2, 4'h3};
    output_channel_common_config dut (.*);
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // derived outputs lag the register by one edge, so wait it out
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
        v = reg_rdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (ROWS[i]) begin
            rd(ROWS[i][22:16], d);
            chk("reset value", ROWS[i][15:0], d);
            wr(ROWS[i][22:16], ~ROWS[i][15:0]);
            rd(ROWS[i][22:16], d);
            chk("readback", ~ROWS[i][15:0], d);
        end
        chk("all inverted", 16'h0001, {15'h0000, all_channel_reset});
        chk("divider all", 16'h000F, {12'h000, divider_clock_select});
        wr(7'h40, 16'hFFFF);
        rd(7'h40, d);
        chk("unmapped", 16'h0000, d);
        foreach (CODES[i]) begin
            wr(7'h3B, {7'h00, CODES[i], 5'h00});
            chk("tail ua", 16'(16'h015E + 16'h0032 * i), {6'h00, tail_current_ua});
            chk("tail trim", {12'h000, CODES[i]}, {12'h000, tail_current_trim});
            chk("tail valid", 16'h0001, {15'h0000, tail_current_valid});
        end
        wr(7'h3B, 16'h00A0);
        chk("tail ua undef", 16'h0000, {6'h00, tail_current_ua});
        chk("tail undef", 16'h0000, {15'h0000, tail_current_valid});
        // only one common-mode trim nonzero at a time
        wr(7'h3B, 16'h1000);
        chk("cm inc", 16'h0002, {14'h0000, cm_trim_inc});
        chk("cm dec idle", 16'h0000, {14'h0000, cm_trim_dec});
        wr(7'h3B, 16'h0400);
        chk("cm dec", 16'h0002, {14'h0000, cm_trim_dec});
        chk("cm inc idle", 16'h0000, {14'h0000, cm_trim_inc});
        // code 2 is undocumented: enabled at normal drive
        for (int r = 0; r < 4; r++) begin
            wr(7'h3B, 16'(r * 2 + 16'h2010 * (r % 2)));
            chk("chan reset", 16'(r % 2), {15'h0000, all_channel_reset});
            chk("cmos fast", 16'(r % 2), {15'h0000, channel_cmos_fast});
            chk("ref on", 16'(r != 0), {15'h0000, reference_copy_output_enable});
            chk("ref fast", 16'(r == 3), {15'h0000, reference_copy_output_fast});
        end
        wr(7'h3D, 16'h15A0);
        chk("divider sel", 16'h000A, {12'h000, divider_clock_select});
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(7'h3D, d);
        chk("reset again", 16'h1500, d);
        chk("cmos reset", 16'h0001, {15'h0000, channel_cmos_fast});
        chk("ua reset", 16'h028A, {6'h00, tail_current_ua});
        chk("sel reset", 16'h0000, {12'h000, divider_clock_select});
        chk("chan rst reset", 16'h0000, {15'h0000, all_channel_reset});
        wrap_up();
    end
endmodule // output_channel_common_config_tb_top
bind output_channel_common_config common_config_checker #(.NUM_CHANNELS(NUM_CHANNELS)) chk_i (.*);
`default_nettype wire
